/* File: hdl/pisc_top.sv */
// pixel input strap control: edge select, de-skew, power-down, hot plug
// assumes straps and pixel clock/data come from outside clk_i's domain
// and the register port is driven from logic on clk_i
//
// The address-and-strobe port and the register offsets were left to the implementer.
`default_nettype none

module pisc_top #(
  parameter int PIX_W = 24
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // strap and shared pins
  input wire logic host_control_select_i,
  input wire logic latch_edge_or_plug_detect_i,
  input wire logic deskew_enable_strap_i,
  input wire logic [pisc_pkg::TRIM_W-1:0] deskew_trim_strap_i,
  input wire logic powerdown_n_i,
  // pixel link
  input wire logic pixel_clock_pos_i,
  input wire logic [PIX_W-1:0] pixel_data_i,
  // register port
  input wire logic [pisc_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic [pisc_pkg::DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [pisc_pkg::DATA_W-1:0] reg_rdata_o,
  // latched pixels
  output logic [PIX_W-1:0] pixel_data_o,
  output logic pixel_valid_o,
  // effective configuration
  output logic latch_rising_o,
  output logic deskew_en_o,
  output logic [pisc_pkg::TRIM_W-1:0] deskew_trim_o,
  output logic power_on_o,
  output logic hot_plug_o,
  // interrupt
  output logic irq_o
);

  import pisc_pkg::*;

  // synchronised pins
  logic sel;
  logic edge_pin;
  logic deskew_enable_strap_pin;
  logic [TRIM_W-1:0] trim_pin;
  logic pd_n_pin;
  logic pclk;
  logic [PIX_W-1:0] pdata;

  // registers and local state
  logic [31:0] ctrl;
  logic [IRQ_W-1:0] irq_stat;
  logic [IRQ_W-1:0] irq_mask;
  logic [31:0] latch_cnt;
  logic sel_d;
  logic pclk_d;
  logic hpd_d;
  logic pwr_d;
  pisc_state_e state;
  logic [DLY_W-1:0] cnt;

  // combinational helpers
  logic wr_ctrl;
  logic wr_stat;
  logic wr_mask;
  logic rise_ev;
  logic fall_ev;
  logic edge_ev;
  logic [DLY_W-1:0] delay;
  logic [IRQ_W-1:0] ev;
  logic [31:0] status;
  logic capture;

  // straps pass the three-flop filter
  pisc_sync #(
    .W(4 + TRIM_W)
  ) u_strap_sync (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .d_i({host_control_select_i, latch_edge_or_plug_detect_i,
          deskew_enable_strap_i, deskew_trim_strap_i, powerdown_n_i}),
    .q_o({sel, edge_pin, deskew_enable_strap_pin, trim_pin, pd_n_pin})
  );

  // clock and data share one filter so they keep the same latency
  pisc_sync #(
    .W(PIX_W + 1)
  ) u_pixel_sync (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .d_i({pixel_clock_pos_i, pixel_data_i}),
    .q_o({pclk, pdata})
  );

  // register write decode
  assign wr_ctrl = reg_wr_i && (reg_addr_i == OFS_CTRL);
  assign wr_stat = reg_wr_i && (reg_addr_i == OFS_IRQ_STAT);
  assign wr_mask = reg_wr_i && (reg_addr_i == OFS_IRQ_MASK);

  // management enable history, used for the start-up default
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      sel_d <= 1'b0;
    end
    else
    begin
      sel_d <= sel;
    end
  end

  // control register: reloads on management start or a reset write,
  // so power reads as down until software sets it again
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      ctrl <= CTRL_RESET;
    end
    else if (sel && !sel_d)
    begin
      ctrl <= CTRL_RESET;
    end
    else if (wr_ctrl && reg_wdata_i[CTRL_MRST])
    begin
      ctrl <= CTRL_RESET;
    end
    else if (wr_ctrl)
    begin
      ctrl <= reg_wdata_i & CTRL_WMASK;
    end
  end

  // effective configuration: software when managed, straps otherwise; hot plug follows the shared pin when managed and is low otherwise
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      latch_rising_o <= 1'b1;
      deskew_en_o <= 1'b0;
      deskew_trim_o <= DEFAULT_TRIM;
      power_on_o <= 1'b0;
      hot_plug_o <= 1'b0;
    end
    else if (sel)
    begin
      // strap levels of de-skew and power-down play no part here
      latch_rising_o <= ctrl[CTRL_RISE];
      deskew_en_o <= ctrl[CTRL_DESKEW_ENABLE_STRAP];
      deskew_trim_o <= ctrl[CTRL_DESKEW_ENABLE_STRAP] ?
        ctrl[CTRL_TRIM_LSB +: TRIM_W] : DEFAULT_TRIM;
      power_on_o <= ctrl[CTRL_PWR];
      hot_plug_o <= edge_pin;
    end
    else
    begin
      latch_rising_o <= edge_pin;
      deskew_en_o <= deskew_enable_strap_pin;
      deskew_trim_o <= deskew_enable_strap_pin ? trim_pin : DEFAULT_TRIM;
      power_on_o <= pd_n_pin;
      hot_plug_o <= 1'b0;
    end
  end

  // pixel clock edges, found on the filtered copy
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      pclk_d <= 1'b0;
    end
    else
    begin
      pclk_d <= pclk;
    end
  end

  assign rise_ev = pclk && !pclk_d;
  assign fall_ev = !pclk && pclk_d;
  assign edge_ev = latch_rising_o ? rise_ev : fall_ev;

  // sampling point sits trim steps after the chosen edge
  assign delay = DLY_W'(deskew_trim_o) * DLY_W'(STEP_CYC);

  // latch sequencer; a new edge while waiting is dropped, which is
  // safe as long as the pixel period exceeds the longest trim
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      state <= PISC_IDLE;
      cnt <= '0;
    end
    else
    begin
      case (state)
        PISC_IDLE:
        begin
          if (edge_ev && power_on_o && (delay != '0))
          begin
            state <= PISC_WAIT;
            cnt <= delay;
          end
        end
        PISC_WAIT:
        begin
          if (!power_on_o || (cnt <= DLY_W'(1)))
          begin
            state <= PISC_IDLE;
          end
          cnt <= cnt - DLY_W'(1);
        end
        default:
        begin
          state <= PISC_IDLE;
        end
      endcase
    end
  end

  // capture moment: immediately for zero delay, else at count end
  always_comb
  begin
    capture = 1'b0;
    case (state)
      PISC_IDLE:
      begin
        capture = edge_ev && power_on_o && (delay == '0);
      end
      PISC_WAIT:
      begin
        capture = power_on_o && (cnt <= DLY_W'(1));
      end
      default:
      begin
        capture = 1'b0;
      end
    endcase
  end

  // primary latch; held still while powered down
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      pixel_data_o <= '0;
      pixel_valid_o <= 1'b0;
    end
    else
    begin
      pixel_valid_o <= capture;
      if (capture)
      begin
        pixel_data_o <= pdata;
      end
    end
  end

  // count of latched pixels, readable by software
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      latch_cnt <= '0;
    end
    else if (capture)
    begin
      latch_cnt <= latch_cnt + 32'h1;
    end
  end

  // history for the interrupt events
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      hpd_d <= 1'b0;
      pwr_d <= 1'b0;
    end
    else
    begin
      hpd_d <= hot_plug_o;
      pwr_d <= power_on_o;
    end
  end

  // events: hot-plug change, power change, management mode change
  always_comb
  begin
    ev = '0;
    ev[IRQ_HPD] = hot_plug_o != hpd_d;
    ev[IRQ_PWR] = power_on_o != pwr_d;
    ev[IRQ_MODE] = sel != sel_d;
  end

  // sticky status, write one to clear; a new event beats the clear
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      irq_stat <= '0;
    end
    else
    begin
      irq_stat <= (irq_stat & ~(wr_stat ? reg_wdata_i[IRQ_W-1:0] : '0))
        | ev;
    end
  end

  // interrupt mask
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      irq_mask <= '0;
    end
    else if (wr_mask)
    begin
      irq_mask <= reg_wdata_i[IRQ_W-1:0];
    end
  end

  // level interrupt, one cycle behind the status bits
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      irq_o <= 1'b0;
    end
    else
    begin
      irq_o <= |(irq_stat & irq_mask);
    end
  end

  // live state word for software
  always_comb
  begin
    status = '0;
    status[ST_SEL] = sel;
    status[ST_HPD] = hot_plug_o;
    status[ST_PWR] = power_on_o;
    status[ST_DESKEW_ENABLE_STRAP] = deskew_en_o;
    status[ST_TRIM_LSB +: TRIM_W] = deskew_trim_o;
    status[ST_RISE] = latch_rising_o;
  end

  // read data for one cycle only; unmapped offsets read zero
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      reg_rdata_o <= '0;
    end
    else if (reg_rd_i)
    begin
      case (reg_addr_i)
        OFS_CTRL: reg_rdata_o <= ctrl;
        OFS_STATUS: reg_rdata_o <= status;
        OFS_IRQ_STAT: reg_rdata_o <= {{(32 - IRQ_W){1'b0}}, irq_stat};
        OFS_IRQ_MASK: reg_rdata_o <= {{(32 - IRQ_W){1'b0}}, irq_mask};
        OFS_LATCH_CNT: reg_rdata_o <= latch_cnt;
        default: reg_rdata_o <= '0;
      endcase
    end
    else
    begin
      reg_rdata_o <= '0;
    end
  end

endmodule

`default_nettype wire

/* File: pkg/pisc_pkg.sv */
// constants and types for the pixel input strap control block
// assumes a 100 MHz core clock and pins that arrive from outside it
//
// Function
// - with management off, the primary latch uses the rising pixel clock edge when the edge strap is high and the falling edge when it is low.
// - with management on, the shared edge/plug pin is a hot-plug detect monitor, not an edge selector.
// - with de-skew on, the sampling point moves in trim increments of one fixed step each.
// - with management off, a high de-skew strap enables de-skew and the three trim straps give the increment.
// - with management off and the de-skew strap low, de-skew is off and the default trim applies.
// - with management on, de-skew enable and trim come from software settings, not from the straps.
// - power-down is active low and halts everything but the pins and the management port.
// - with management off, the device follows the power-down pin, high for run, low for power-down.
// - with management on, a software power bit decides, and it reads power-down when management starts or is reset.
`default_nettype none

package pisc_pkg;

  // clock and trim step timing
  localparam int CLK_MHZ = 100;
  localparam int STEP_NS = 10;
  localparam int STEP_CYC_RAW = (STEP_NS * CLK_MHZ) / 1000;
  localparam int STEP_CYC = (STEP_CYC_RAW < 1) ? 1 : STEP_CYC_RAW;

  // register bus
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h0c;
  localparam logic [7:0] OFS_LATCH_CNT = 8'h10;

  // control register fields
  localparam int TRIM_W = 3;
  localparam int CTRL_PWR = 0;
  localparam int CTRL_DESKEW_ENABLE_STRAP = 1;
  localparam int CTRL_TRIM_LSB = 2;
  localparam int CTRL_RISE = 5;
  localparam int CTRL_MRST = 8;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0020;
  localparam logic [31:0] CTRL_WMASK = 32'h0000_003f;
  localparam logic [2:0] DEFAULT_TRIM = 3'h3;

  // status register fields
  localparam int ST_SEL = 0;
  localparam int ST_HPD = 1;
  localparam int ST_PWR = 2;
  localparam int ST_DESKEW_ENABLE_STRAP = 3;
  localparam int ST_TRIM_LSB = 4;
  localparam int ST_RISE = 7;

  // interrupt bits
  localparam int IRQ_W = 3;
  localparam int IRQ_HPD = 0;
  localparam int IRQ_PWR = 1;
  localparam int IRQ_MODE = 2;

  // delay counter width, enough for 7 steps
  localparam int DLY_W = 8;

  typedef enum logic [0:0] {
    PISC_IDLE,
    PISC_WAIT
  } pisc_state_e;

endpackage

`default_nettype wire

/* File: hdl/pisc_sync.sv */
// three-stage pin synchroniser with agreement filter
// assumes inputs are asynchronous to clk_i
`default_nettype none

module pisc_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // asynchronous in, filtered out
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  // s1 feeds only s2; a bit moves once s2 and s3 agree
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      q_o <= '0;
    end
    else
    begin
      s1 <= d_i;
      s2 <= s1;
      s3 <= s2;
      for (int i = 0; i < W; i++)
      begin
        if (s2[i] == s3[i])
        begin
          q_o[i] <= s3[i];
        end
      end
    end
  end

endmodule

`default_nettype wire

/* File: sim/pisc_props.sv */
// checker on the top ports of the strap control block
// assumes one clock domain and a synchronous active-low reset
`default_nettype none

module pisc_props (
  // clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // pins
  input wire logic host_control_select_i,
  input wire logic latch_edge_or_plug_detect_i,
  input wire logic deskew_enable_strap_i,
  input wire logic [pisc_pkg::TRIM_W-1:0] deskew_trim_strap_i,
  input wire logic powerdown_n_i,
  // outputs
  input wire logic pixel_valid_o,
  input wire logic latch_rising_o,
  input wire logic deskew_en_o,
  input wire logic [pisc_pkg::TRIM_W-1:0] deskew_trim_o,
  input wire logic power_on_o,
  input wire logic hot_plug_o
);
  timeunit 1ns;
  timeprecision 1ns;
  import pisc_pkg::*;
  logic [6:0] pins;
  logic [6:0] pins_q;
  logic [3:0] quiet;
  logic st;
  logic um;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  // judge only settled pins: the filter and config flops lag a few cycles
  assign pins = {host_control_select_i, latch_edge_or_plug_detect_i,
    deskew_enable_strap_i, deskew_trim_strap_i, powerdown_n_i};
  assign st = quiet[3] && pins == pins_q;
  assign um = st && !host_control_select_i;
  // quiet cycles since the last pin move, saturating at eight
  always_ff @(posedge clk_i)
  begin
    pins_q <= pins;
    if (!resetn_i || pins != pins_q)
      quiet <= 4'h0;
    else if (!quiet[3])
      quiet <= quiet + 4'h1;
  end
  property p_rise;
    um |-> latch_rising_o == latch_edge_or_plug_detect_i;
  endproperty
  a_rise: assert property (p_rise)
    else $error("latch edge off strap");
  property p_hpd;
    st |-> hot_plug_o ==
      (host_control_select_i && latch_edge_or_plug_detect_i);
  endproperty
  a_hpd: assert property (p_hpd)
    else $error("hot plug off pin");
  property p_deskew_enable_strap;
    um |-> deskew_en_o == deskew_enable_strap_i;
  endproperty
  a_deskew_enable_strap: assert property (p_deskew_enable_strap)
    else $error("deskew enable off strap");
  property p_trim;
    um && deskew_enable_strap_i |-> deskew_trim_o == deskew_trim_strap_i;
  endproperty
  a_trim: assert property (p_trim)
    else $error("trim off strap");
  property p_dflt;
    um && !deskew_enable_strap_i |-> deskew_trim_o == DEFAULT_TRIM;
  endproperty
  a_dflt: assert property (p_dflt)
    else $error("default trim wrong");
  property p_pwr;
    um |-> power_on_o == powerdown_n_i;
  endproperty
  a_pwr: assert property (p_pwr)
    else $error("power off pin");
  property p_pd;
    !power_on_o [*8] |=> !pixel_valid_o;
  endproperty
  a_pd: assert property (p_pd)
    else $error("pixel while powered down");
  property p_mgd;
    $rose(host_control_select_i) |-> ##[1:8] !power_on_o;
  endproperty
  a_mgd: assert property (p_mgd)
    else $error("managed start not powered down");
endmodule

bind pisc_top pisc_props i_pisc_props (
  .clk_i(clk_i), .resetn_i(resetn_i),
  .host_control_select_i(host_control_select_i),
  .latch_edge_or_plug_detect_i(latch_edge_or_plug_detect_i),
  .deskew_enable_strap_i(deskew_enable_strap_i),
  .deskew_trim_strap_i(deskew_trim_strap_i),
  .powerdown_n_i(powerdown_n_i), .pixel_valid_o(pixel_valid_o),
  .latch_rising_o(latch_rising_o), .deskew_en_o(deskew_en_o),
  .deskew_trim_o(deskew_trim_o), .power_on_o(power_on_o),
  .hot_plug_o(hot_plug_o)
);

`default_nettype wire

/* File: sim/pisc_gfx_model.sv */
// graphics controller model: pixel clock and data words
// assumes the bench raises run_i for a frame and picks the latch edge
`default_nettype none

module pisc_gfx_model (
  // frame control
  input wire logic run_i,
  input wire logic rise_i,
  // pixel link
  output logic clk_o,
  output logic [23:0] data_o,
  // last latched word, count and time of latch edges
  output logic [23:0] last_o,
  output int lat_o,
  output int t_o
);
  timeunit 1ns;
  timeprecision 1ns;
  int half;
  int quiet;
  // clock stands low between frames; idle data toggles only once the
  // last word has stood a full period, so a late trim never sees noise
  initial
  begin
    clk_o = 1'b0;
    data_o = 24'h0;
    last_o = 24'h0;
    lat_o = 0;
    t_o = 0;
    half = 40;
    quiet = 0;
    forever
    begin
      if (!run_i && !clk_o)
      begin
        #10 quiet++;
        if (quiet > 8)
          data_o = ~data_o;
      end
      else
      begin
        quiet = 0;
        #(half) clk_o = ~clk_o;
        half = 40;
        if (clk_o == rise_i)
        begin
          last_o = data_o;
          lat_o++;
          t_o = int'($time);
        end
        else
        begin
          // a word moves just before the next latch edge: it stands 78 ns
          // past its own edge, so the longest trim sees it
          #38 data_o = data_o + 24'h010203;
          half = 2;
        end
      end
    end
  end
endmodule

`default_nettype wire

/* File: sim/pisc_top_test.sv */
// bench for the pixel input strap control top
// pins and register port driven here; a model drives the pixel link
`default_nettype none

module pisc_top_test;
  timeunit 1ns;
  timeprecision 1ns;
  import pisc_pkg::*;
  logic clk = 1'b0, resetn = 1'b0, sel = 1'b0, edg = 1'b0;
  logic deskew_enable_strap = 1'b0, pdn_n = 1'b0, run = 1'b0, mrise = 1'b0;
  logic wr = 1'b0, rd = 1'b0;
  logic [TRIM_W-1:0] trim = 3'h0;
  logic [ADDR_W-1:0] addr = 8'h00;
  logic [DATA_W-1:0] wdata = 32'h0, rdata;
  logic [23:0] pdat, last, pix;
  logic pclk, valid, l_rise, d_en, pwr, hpd, irq;
  logic [TRIM_W-1:0] d_trim;
  int lat, t_edge, err_total = 0, total_checks = 0, nval = 0, dly = 0;

  pisc_top i_pisc_top (
    .clk_i(clk), .resetn_i(resetn), .host_control_select_i(sel),
    .latch_edge_or_plug_detect_i(edg), .deskew_enable_strap_i(deskew_enable_strap),
    .deskew_trim_strap_i(trim), .powerdown_n_i(pdn_n),
    .pixel_clock_pos_i(pclk), .pixel_data_i(pdat), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_rdata_o(rdata), .pixel_data_o(pix), .pixel_valid_o(valid),
    .latch_rising_o(l_rise), .deskew_en_o(d_en), .deskew_trim_o(d_trim),
    .power_on_o(pwr), .hot_plug_o(hpd), .irq_o(irq)
  );
  pisc_gfx_model i_pisc_gfx_model (
    .run_i(run), .rise_i(mrise), .clk_o(pclk), .data_o(pdat),
    .last_o(last), .lat_o(lat), .t_o(t_edge)
  );

  initial
  begin
    forever
      #5 clk = ~clk;
  end

  // count pixels and keep the latency of the latest one
  always @(posedge clk)
  begin
    if (valid === 1'b1)
    begin
      nval <= nval + 1;
      dly <= int'($time) - t_edge;
    end
  end

  task automatic chk(input string n, input logic [31:0] got,
    input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch %s expected %h seen %h", n, exp, got);
    end
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // pin filter plus config flop take about five cycles
  task automatic settle;
    repeat (10) @(posedge clk);
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd_reg(input string n, input logic [7:0] a,
    input logic [31:0] e);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(n, rdata, e);
    @(posedge clk);
  endtask

  task automatic frame(input logic on, output int d);
    int n0;
    int l0;
    n0 = nval;
    l0 = lat;
    run <= 1'b1;
    repeat (40) @(posedge clk);
    run <= 1'b0;
    repeat (30) @(posedge clk);
    chk("pixels", nval - n0, on ? lat - l0 : 0);
    if (on)
      chk("pixel word", pix, last);
    d = dly;
  endtask

  task automatic t_strap;
    int d1;
    int d3;
    sel <= 1'b0;
    pdn_n <= 1'b1;
    trim <= 3'h5;
    for (int i = 0; i < 4; i++)
    begin
      edg <= i[0];
      mrise <= i[0];
      deskew_enable_strap <= i[1];
      settle();
      chk("latch edge", l_rise, i[0]);
      chk("deskew on", d_en, i[1]);
      chk("trim", d_trim, i[1] ? 3'h5 : DEFAULT_TRIM);
      chk("power", pwr, 1'b1);
      frame(1'b1, d3);
      if (i == 1)
        d1 = d3;
    end
    chk("step delay", d3 - d1, 2 * STEP_CYC * 10);
    $display("test strap done");
  endtask

  task automatic t_power;
    int d;
    // drop the power-up event first, so only the power drop can raise irq
    wr_reg(OFS_IRQ_STAT, 32'h1 << IRQ_PWR);
    wr_reg(OFS_IRQ_MASK, 32'h1 << IRQ_PWR);
    settle();
    chk("irq idle", irq, 1'b0);
    pdn_n <= 1'b0;
    settle();
    chk("power", pwr, 1'b0);
    chk("irq raised", irq, 1'b1);
    frame(1'b0, d);
    wr_reg(OFS_IRQ_MASK, 32'h0);
    settle();
    chk("irq masked", irq, 1'b0);
    wr_reg(OFS_IRQ_MASK, 32'h1 << IRQ_PWR);
    wr_reg(OFS_IRQ_STAT, 32'h1 << IRQ_PWR);
    settle();
    chk("irq cleared", irq, 1'b0);
    pdn_n <= 1'b1;
    settle();
    $display("test power done");
  endtask

  task automatic t_managed;
    int d;
    sel <= 1'b1;
    deskew_enable_strap <= 1'b1;
    settle();
    chk("power", pwr, 1'b0);
    chk("deskew on", d_en, 1'b0);
    edg <= 1'b1;
    settle();
    chk("hot plug", hpd, 1'b1);
    edg <= 1'b0;
    settle();
    chk("hot plug", hpd, 1'b0);
    chk("latch edge", l_rise, 1'b1);
    wr_reg(OFS_CTRL, 32'h13);
    settle();
    chk("power", pwr, 1'b1);
    chk("deskew on", d_en, 1'b1);
    chk("trim", d_trim, 3'h4);
    mrise <= 1'b0;
    frame(1'b1, d);
    pdn_n <= 1'b0;
    deskew_enable_strap <= 1'b0;
    settle();
    chk("power", pwr, 1'b1);
    chk("deskew on", d_en, 1'b1);
    rd_reg("status", OFS_STATUS, 32'h4d);
    wr_reg(OFS_CTRL, 32'h100);
    settle();
    chk("power", pwr, 1'b0);
    rd_reg("control", OFS_CTRL, CTRL_RESET);
    rd_reg("unmapped", 8'h20, 32'h0);
    $display("test managed done");
  endtask

  initial
  begin
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    t_strap();
    t_power();
    t_managed();
    results();
  end

  // cut a hang short
  initial
  begin
    repeat (20000) @(posedge clk);
    err_total++;
    results();
  end
endmodule

`default_nettype wire
